//--- adcavg_defs.vh
// Purpose: Constants of the converter result averaging block.
// Assumes: Verilog-2005 and SystemVerilog includers; one 10 MHz clock.
// Notes:   Register offsets are word indices on the plain register port.
//
// How it works
// - Sum samples, divide, store in result.
// - Count code n up to 10 selects 2^n samples; reserved codes select one.
// - Sum widens one bit per doubling.
// - Above sixteen samples, auto shift keeps 16 bits.
// - Software coefficient adds further right shift.
// - Total shift is auto plus coefficient; log2 count gives 12 bits.
// - One result per group of samples.
// - Ready flag only after final result.
`ifndef ADCAVG_DEFS_VH
`define ADCAVG_DEFS_VH

// ****************************************************************
// Register map
// ****************************************************************
`define ADCAVG_ADDR_AVERAGE_CONTROL_REG   4'h0
`define ADCAVG_ADDR_CONTROL_C_REG     4'h1
`define ADCAVG_ADDR_RESULT    4'h2
`define ADCAVG_ADDR_INTERRUPT_FLAG_REG   4'h3
`define ADCAVG_ADDR_INTMASK   4'h4
`define ADCAVG_ADDR_STATUS    4'h5

// ****************************************************************
// Fields
// ****************************************************************
`define ADCAVG_CNT_LSB        0
`define ADCAVG_CNT_MSB        3
`define ADCAVG_ADJ_LSB        4
`define ADCAVG_ADJ_MSB        6
`define ADCAVG_RES_LSB        0
`define ADCAVG_RES_MSB        1
`define ADCAVG_RES_AVERAGE    2'h1
`define ADCAVG_CNT_MAX        4'hA
`define ADCAVG_AUTO_FREE      4'h4
`define ADCAVG_FLAG_READY     0
`define ADCAVG_FLAG_OVERRUN   1
`define ADCAVG_AVERAGE_CONTROL_REG_RESET  7'h00
`define ADCAVG_CONTROL_C_REG_RESET    2'h0

`endif

//--- adcavg_shift.v
// Purpose: Combined automatic and programmed right shift of a sum.
// Assumes: Count code already limited to the supported range.
// Notes:   Purely combinational.
`timescale 1ns/1ns
`include "adcavg_defs.vh"

module adcavg_shift #(
  parameter ACC_W = 22,
  parameter OUT_W = 16
) (
  // Operands
  input  wire [ACC_W-1:0] sumIn,
  input  wire [3:0]       countCode,
  input  wire [2:0]       adjShift,
  // Result
  output wire [OUT_W-1:0] shiftedOut
);

  wire [3:0]       autoShift;
  wire [4:0]       totalShift;
  wire [ACC_W-1:0] shifted;

  assign autoShift = (countCode > `ADCAVG_AUTO_FREE) ?
                     (countCode - `ADCAVG_AUTO_FREE) : 4'h0;
  assign totalShift = {1'b0, autoShift} + {2'b00, adjShift};
  assign shifted    = sumIn >> totalShift;
  assign shiftedOut = shifted[OUT_W-1:0];

endmodule // adcavg_shift

//--- adcavg_regs.v
// Purpose: Sticky interrupt flags with mask and write-one clear.
// Assumes: Event pulses come from logic on the same clock.
// Notes:   A set in the clearing cycle wins.
`timescale 1ns/1ns

module adcavg_regs #(
  parameter N = 2
) (
  // Clock and reset
  input  wire         clk,
  input  wire         srst,
  // Events and software access
  input  wire [N-1:0] eventIn,
  input  wire         clearWr,
  input  wire [N-1:0] clearData,
  input  wire         maskWr,
  input  wire [N-1:0] maskData,
  // State
  output reg  [N-1:0] flag_reg,
  output reg  [N-1:0] mask_reg,
  output wire         irq
);

  wire [N-1:0] flag_next;

  assign flag_next = (flag_reg & ~(clearWr ? clearData : {N{1'b0}}))
                     | eventIn;
  assign irq = |(flag_reg & mask_reg);

  always @(posedge clk) begin
    if (srst) begin
      flag_reg <= {N{1'b0}};
      mask_reg <= {N{1'b0}};
    end else begin
      flag_reg <= flag_next;
      if (maskWr) begin
        mask_reg <= maskData;
      end
    end
  end

endmodule // adcavg_regs

//--- adcavg_top.v
// Purpose: Accumulates converter samples and delivers averaged results.
// Assumes: Samples arrive as one-cycle strobes on the same clock.
// Notes:   Reserved count codes act as a single sample.
`timescale 1ns/1ns
`include "adcavg_defs.vh"

module adcavg_top #(
  parameter SAMPLE_W = 12,
  parameter RESULT_W = 16,
  parameter ACC_W    = 22
) (
  // Clock and reset
  input  wire                clk,
  input  wire                srst,
  // Converter core
  input  wire                sampleValid,
  input  wire [SAMPLE_W-1:0] sampleData,
  // Register port
  input  wire [3:0]          regAddr,
  input  wire [31:0]         regWdata,
  input  wire                regWr,
  input  wire                regRd,
  output reg  [31:0]         regRdata,
  // Outputs
  output wire                irq,
  output wire                resultReady
);

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  reg  [3:0]          sampleCountSelect_reg;
  reg  [2:0]          divisionShiftCoefficient_reg;
  reg  [1:0]          resultResolutionSelect_reg;
  reg  [RESULT_W-1:0] result_reg;
  reg  [ACC_W-1:0]    acc_reg;
  reg  [10:0]         count_reg;
  reg                 resultReadyPulse_reg;
  reg                 overrun_reg;

  wire [3:0]          effCode;
  wire [10:0]         groupSize;
  wire                wrAvg;
  wire                wrCtrlc;
  wire [ACC_W-1:0]    sumNow;
  wire [RESULT_W-1:0] shiftedSum;
  wire                groupDone;
  wire [1:0]          flagReg;
  wire [1:0]          maskReg;

  // reserved codes fall back to one sample
  assign effCode = (sampleCountSelect_reg > `ADCAVG_CNT_MAX) ?
                   4'h0 : sampleCountSelect_reg;
  assign groupSize = 11'h001 << effCode;
  assign wrAvg   = regWr && (regAddr == `ADCAVG_ADDR_AVERAGE_CONTROL_REG);
  assign wrCtrlc = regWr && (regAddr == `ADCAVG_ADDR_CONTROL_C_REG);

  always @(posedge clk) begin
    if (srst) begin
      sampleCountSelect_reg        <= 4'h0;
      divisionShiftCoefficient_reg <= 3'h0;
      resultResolutionSelect_reg   <= `ADCAVG_CONTROL_C_REG_RESET;
    end else begin
      if (wrAvg) begin
        sampleCountSelect_reg <=
          regWdata[`ADCAVG_CNT_MSB:`ADCAVG_CNT_LSB];
        divisionShiftCoefficient_reg <=
          regWdata[`ADCAVG_ADJ_MSB:`ADCAVG_ADJ_LSB];
      end
      if (wrCtrlc) begin
        resultResolutionSelect_reg <=
          regWdata[`ADCAVG_RES_MSB:`ADCAVG_RES_LSB];
      end
    end
  end

  // ****************************************************************
  // Accumulator
  // ****************************************************************
  // sum widens with count
  assign sumNow = acc_reg + {{(ACC_W-SAMPLE_W){1'b0}}, sampleData};
  assign groupDone = sampleValid && ((count_reg + 11'h001) >= groupSize);

  adcavg_shift #(
    .ACC_W (ACC_W),
    .OUT_W (RESULT_W)
  ) uShift (
    .sumIn      (sumNow),
    .countCode  (effCode),
    .adjShift   (divisionShiftCoefficient_reg),
    .shiftedOut (shiftedSum)
  );

  // A config write restarts the group so no result mixes two settings.
  always @(posedge clk) begin
    if (srst) begin
      acc_reg              <= {ACC_W{1'b0}};
      count_reg            <= 11'h000;
      result_reg           <= {RESULT_W{1'b0}};
      resultReadyPulse_reg <= 1'b0;
      overrun_reg          <= 1'b0;
    end else begin
      resultReadyPulse_reg <= 1'b0;
      overrun_reg          <= 1'b0;
      if (wrAvg || wrCtrlc) begin
        acc_reg   <= {ACC_W{1'b0}};
        count_reg <= 11'h000;
      end else if (groupDone) begin
        result_reg           <= shiftedSum;
        resultReadyPulse_reg <= 1'b1;
        overrun_reg          <= flagReg[`ADCAVG_FLAG_READY];
        acc_reg              <= {ACC_W{1'b0}};
        count_reg            <= 11'h000;
      end else if (sampleValid) begin
        acc_reg   <= sumNow;
        count_reg <= count_reg + 11'h001;
      end
    end
  end

  // ****************************************************************
  // Interrupt flags
  // ****************************************************************
  adcavg_regs #(
    .N (2)
  ) uFlags (
    .clk       (clk),
    .srst      (srst),
    .eventIn   ({overrun_reg, resultReadyPulse_reg}),
    .clearWr   (regWr && (regAddr == `ADCAVG_ADDR_INTERRUPT_FLAG_REG)),
    .clearData (regWdata[1:0]),
    .maskWr    (regWr && (regAddr == `ADCAVG_ADDR_INTMASK)),
    .maskData  (regWdata[1:0]),
    .flag_reg  (flagReg),
    .mask_reg  (maskReg),
    .irq       (irq)
  );

  assign resultReady = flagReg[`ADCAVG_FLAG_READY];

  // ****************************************************************
  // Read port
  // ****************************************************************
  always @(posedge clk) begin
    if (srst) begin
      regRdata <= 32'h00000000;
    end else if (regRd) begin
      case (regAddr)
        `ADCAVG_ADDR_AVERAGE_CONTROL_REG:
          regRdata <= {25'h0000000, divisionShiftCoefficient_reg,
                       sampleCountSelect_reg};
        `ADCAVG_ADDR_CONTROL_C_REG:
          regRdata <= {30'h00000000, resultResolutionSelect_reg};
        `ADCAVG_ADDR_RESULT:
          regRdata <= {{(32-RESULT_W){1'b0}}, result_reg};
        `ADCAVG_ADDR_INTERRUPT_FLAG_REG:
          regRdata <= {30'h00000000, flagReg};
        `ADCAVG_ADDR_INTMASK:
          regRdata <= {30'h00000000, maskReg};
        `ADCAVG_ADDR_STATUS:
          regRdata <= {21'h000000, count_reg};
        default:
          regRdata <= 32'h00000000;
      endcase
    end else begin
      regRdata <= 32'h00000000;
    end
  end

endmodule // adcavg_top

//--- adcavg_sva.sv
// Purpose: Port checker of the averaging block.
// Assumes: One clock, synchronous reset.
// Notes:   Mask bit 0 is shadowed from writes.
`timescale 1ns/1ns
`include "adcavg_defs.vh"
module adcavg_sva #(
  parameter SAMPLE_W = 12,
  parameter RESULT_W = 16,
  parameter ACC_W    = 22
) (
  // Clock and reset
  input wire                clk,
  input wire                srst,
  // Inputs
  input wire                sampleValid,
  input wire [SAMPLE_W-1:0] sampleData,
  input wire [3:0]          regAddr,
  input wire [31:0]         regWdata,
  input wire                regWr,
  input wire                regRd,
  // Outputs
  input wire [31:0]         regRdata,
  input wire                irq,
  input wire                resultReady
);
  reg  mask_reg;
  wire clr = regWr && regAddr == `ADCAVG_ADDR_INTERRUPT_FLAG_REG && regWdata[0];
  always @(posedge clk) begin
    if (srst)
      mask_reg <= 1'b0;
    else if (regWr && regAddr == `ADCAVG_ADDR_INTMASK)
      mask_reg <= regWdata[0];
  end
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // ****
  // Checks
  // ****
  chk_rdata_idle: assert property (!$past(regRd) |-> !regRdata)
    else $error("read data not idle");
  chk_unmapped_zero: assert property (regRd && regAddr > 4'h5 |=> !regRdata)
    else $error("unmapped read not zero");
  chk_flag_read: assert property (regRd && regAddr == 4'h3 |=>
    regRdata[0] == $past(resultReady)) else $error("flag read wrong");
  chk_ready_sticky: assert property (resultReady && !clr |=> resultReady)
    else $error("ready lost");
  chk_ready_clear: assert property (clr && !$past(sampleValid)
    |=> !resultReady) else $error("ready not cleared");
  chk_ready_cause: assert property ($rose(resultReady)
    |-> $past(sampleValid, 2)) else $error("ready without sample");
  chk_irq_ready: assert property (resultReady && mask_reg |-> irq)
    else $error("irq missing");
  chk_status_range: assert property (regRd && regAddr == 4'h5 |=>
    regRdata < 32'h00000400) else $error("group count too large");
  chk_reset_quiet: assert property ($fell(srst)
    |-> !resultReady && !irq && !regRdata) else $error("reset state");
endmodule // adcavg_sva
bind adcavg_top adcavg_sva #(.SAMPLE_W(SAMPLE_W), .RESULT_W(RESULT_W),
  .ACC_W(ACC_W)) i_chk (.clk(clk), .srst(srst), .sampleValid(sampleValid),
  .sampleData(sampleData), .regAddr(regAddr), .regWdata(regWdata),
  .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .irq(irq),
  .resultReady(resultReady));

//--- adcavg_core_model.sv
// Purpose: Converter core sending a ramp of samples.
// Assumes: Same clock as the block.
// Notes:   Idle data is inverted so stale values never match.
`timescale 1ns/1ns
module adcavg_core_model (
  // Command
  input wire        clk,
  input wire        go,
  input wire [10:0] nSamples,
  input wire [3:0]  gap,
  input wire [11:0] base,
  // Samples
  output reg        sampleValid,
  output reg [11:0] sampleData,
  output reg        busy
);
  integer i;
  initial begin
    sampleValid = 1'b0;
    sampleData = 12'h5A5;
    busy = 1'b0;
    forever begin
      @(posedge clk);
      if (go === 1'b1) begin
        busy <= 1'b1;
        for (i = 0; i < nSamples; i = i + 1) begin
          sampleValid <= 1'b1;
          sampleData <= base + i[11:0];
          @(posedge clk);
          if (gap != 4'h0) begin
            sampleValid <= 1'b0;
            sampleData <= ~sampleData;
            repeat (gap) @(posedge clk);
          end
        end
        sampleValid <= 1'b0;
        if (gap == 4'h0)
          sampleData <= ~sampleData;
        busy <= 1'b0;
      end
    end
  end
endmodule // adcavg_core_model

//--- tb_top.sv
// Purpose: Self-checking bench of the averaging block.
// Assumes: Core model feeds samples; bench owns registers.
// Notes:   Expected results come from ramp sums.
`timescale 1ns/1ns
`include "adcavg_defs.vh"
module tb_top;
  reg         clk, srst, regWr, regRd, go;
  reg  [3:0]  regAddr, gap;
  reg  [31:0] regWdata;
  reg  [10:0] nSamp;
  reg  [11:0] base;
  wire        sampleValid, irq, resultReady, busy;
  wire [11:0] sampleData;
  wire [31:0] regRdata;
  integer     errors, n_checks, code, adj;
  integer     cycles = 0;
  adcavg_top i_dut (.clk(clk), .srst(srst), .sampleValid(sampleValid),
    .sampleData(sampleData), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .irq(irq),
    .resultReady(resultReady));
  adcavg_core_model i_core (.clk(clk), .go(go), .nSamples(nSamp),
    .gap(gap), .base(base), .sampleValid(sampleValid),
    .sampleData(sampleData), .busy(busy));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors = errors + 1;
      wrap_up;
    end
  end
  task wrap_up;
    begin
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  task chk(input string nm, input [31:0] seen, input [31:0] exp);
    begin
      n_checks = n_checks + 1;
      if (seen !== exp) begin
        errors = errors + 1;
        $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task wr(input [3:0] a, input [31:0] d);
    begin
      @(posedge clk);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge clk);
      regWr <= 1'b0;
    end
  endtask
  task rdc(input [3:0] a, input [31:0] e);
    begin
      @(posedge clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk);
      regRd <= 1'b0;
      #1 chk($sformatf("reg%0h", a), regRdata, e);
    end
  endtask
  // Waits for the model, then three cycles for result and flag.
  task run(input integer n, input integer g, input integer b);
    integer k;
    begin
      @(posedge clk);
      nSamp <= n[10:0];
      gap <= g[3:0];
      base <= b[11:0];
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      @(negedge clk);
      for (k = 0; k < 4000 && busy !== 1'b0; k = k + 1) @(negedge clk);
      chk("busy", busy, 0);
      repeat (3) @(negedge clk);
    end
  endtask
  function [31:0] avg(input integer c, input integer a, input integer b);
    integer n;
    begin
      n = 1 << c;
      avg = ((n * b + n * (n - 1) / 2) >> ((c > 4 ? c - 4 : 0) + a));
      avg = avg & 32'h0000FFFF;
    end
  endfunction
  initial begin
    {errors, n_checks} = 0;
    {srst, regWr, regRd, go} = 4'h8;
    {regAddr, gap, regWdata, nSamp, base} = 0;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    for (code = 0; code < 6; code = code + 1) rdc(code, 0);
    rdc(4'hF, 0);
    wr(`ADCAVG_ADDR_CONTROL_C_REG, `ADCAVG_RES_AVERAGE);
    wr(`ADCAVG_ADDR_INTMASK, 1);
    for (code = 0; code <= 10; code = code + 1) begin
      adj = code > 4 ? 4 : code;
      wr(`ADCAVG_ADDR_AVERAGE_CONTROL_REG, adj << 4 | code);
      run(1 << code, code % 2, 100 + code);
      chk("irq", irq, 1);
      rdc(`ADCAVG_ADDR_RESULT, avg(code, adj, 100 + code));
      wr(`ADCAVG_ADDR_INTERRUPT_FLAG_REG, 1);
      rdc(`ADCAVG_ADDR_INTERRUPT_FLAG_REG, 0);
    end
    wr(`ADCAVG_ADDR_AVERAGE_CONTROL_REG, 32'hB);
    run(1, 0, 321);
    rdc(`ADCAVG_ADDR_RESULT, 321);
    wr(`ADCAVG_ADDR_INTERRUPT_FLAG_REG, 1);
    wr(`ADCAVG_ADDR_AVERAGE_CONTROL_REG, 32'h22);
    run(3, 0, 500);
    chk("ready", resultReady, 0);
    rdc(`ADCAVG_ADDR_STATUS, 3);
    wr(`ADCAVG_ADDR_AVERAGE_CONTROL_REG, 32'h22);
    rdc(`ADCAVG_ADDR_STATUS, 0);
    run(4, 1, 40);
    rdc(`ADCAVG_ADDR_RESULT, avg(2, 2, 40));
    wr(`ADCAVG_ADDR_AVERAGE_CONTROL_REG, 32'h02);
    run(4, 0, 4000);
    rdc(`ADCAVG_ADDR_RESULT, avg(2, 0, 4000));
    wr(`ADCAVG_ADDR_AVERAGE_CONTROL_REG, 32'h13);
    run(8, 0, 2000);
    rdc(`ADCAVG_ADDR_RESULT, avg(3, 1, 2000));
    wr(`ADCAVG_ADDR_AVERAGE_CONTROL_REG, 32'h05);
    run(32, 0, 4000);
    rdc(`ADCAVG_ADDR_RESULT, avg(5, 0, 4000));
    rdc(`ADCAVG_ADDR_INTERRUPT_FLAG_REG, 3);
    wr(`ADCAVG_ADDR_INTMASK, 0);
    @(negedge clk);
    chk("irq", irq, 0);
    wr(`ADCAVG_ADDR_INTERRUPT_FLAG_REG, 3);
    rdc(`ADCAVG_ADDR_INTERRUPT_FLAG_REG, 0);
    wr(`ADCAVG_ADDR_INTMASK, 1);
    wr(`ADCAVG_ADDR_AVERAGE_CONTROL_REG, 32'h00);
    run(1, 0, 9);
    chk("irq", irq, 1);
    wr(`ADCAVG_ADDR_AVERAGE_CONTROL_REG, 32'h22);
    run(3, 0, 9);
    // A reset in mid-group must drop the partial sum and every flag.
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    rdc(`ADCAVG_ADDR_STATUS, 0);
    rdc(`ADCAVG_ADDR_INTERRUPT_FLAG_REG, 0);
    rdc(`ADCAVG_ADDR_RESULT, 0);
    chk("irq", irq, 0);
    run(1, 0, 77);
    rdc(`ADCAVG_ADDR_RESULT, 77);
    wrap_up;
  end
endmodule // tb_top
